/* File: hw/otpg_pkg.sv */
// Notes on behaviour
// - the sequencing bit only acts while the mode field holds the user-pattern code.
// - each of the four user patterns comes from a byte pair, upper byte at the higher index.
// - with the sequencing bit clear, patterns one to four each show for one cycle and repeat.
// - with the sequencing bit set, patterns one to four show once and then zeros follow.
// - the long pseudorandom generator is held at its seed while long_prbs_hold is one.
// - after reset the control fields read zero and the reserved bit always reads zero.
// - the four-bit mode field picks normal samples or one of eight test sources.
// - the short pseudorandom generator is held at its seed while short_prbs_hold is one.
package otpg_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_CTRL = 14'h0550;
  localparam logic [13:0] IDX_PAT_BASE = 14'h0551;
  localparam int NUM_PAT = 4;
  localparam int ADDR_W = 16;

  // ==========================================================
  // control register layout
  typedef struct packed {
    logic seq_once;
    logic rsvd;
    logic long_prbs_hold;
    logic short_prbs_hold;
    logic [3:0] mode;
  } otpg_ctrl_type;

  localparam otpg_ctrl_type CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'hBF;

  // ==========================================================
  // test modes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_MID = 4'h1;
  localparam logic [3:0] MODE_POS = 4'h2;
  localparam logic [3:0] MODE_NEG = 4'h3;
  localparam logic [3:0] MODE_CHECK = 4'h4;
  localparam logic [3:0] MODE_PN_LONG = 4'h5;
  localparam logic [3:0] MODE_PN_SHORT = 4'h6;
  localparam logic [3:0] MODE_TOGGLE = 4'h7;
  localparam logic [3:0] MODE_USER = 4'h8;

  // ==========================================================
  // fixed words and generator seeds
  localparam logic [15:0] WORD_MID = 16'h0000;
  localparam logic [15:0] WORD_POS = 16'h7FFF;
  localparam logic [15:0] WORD_NEG = 16'h8000;
  localparam logic [15:0] WORD_CHECK_A = 16'hAAAA;
  localparam logic [15:0] WORD_CHECK_B = 16'h5555;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [22:0] LONG_SEED = 23'h7FFFFF;
  localparam logic [8:0] SHORT_SEED = 9'h1FF;
  localparam int LONG_TAP = 18;
  localparam int SHORT_TAP = 5;
  localparam logic [1:0] LAST_PAT = 2'h3;
endpackage

/* File: hw/otpg_top.sv */
`timescale 1ns/10ps
module otpg_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [otpg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] sample_in,
  output logic [15:0] out_word
);
  import otpg_pkg::*;

  // ==========================================================
  // bus slave: one wait cycle, then the access completes
  otpg_ctrl_type ctrl_ff;
  logic [7:0] pat_lo_ff [NUM_PAT];
  logic [7:0] pat_hi_ff [NUM_PAT];
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [13:0] idx;
  logic req;
  logic accept_wr;
  logic [13:0] pat_off;
  logic pat_hit;
  logic [31:0] nxt_rdata;

  assign idx = avs_address[ADDR_W-1:2];
  assign req = avs_read | avs_write;
  assign accept_wr = avs_write & ~wait_ff & avs_byteenable[0];
  assign pat_off = idx - IDX_PAT_BASE;
  assign pat_hit = (idx >= IDX_PAT_BASE) && (pat_off < 14'(2 * NUM_PAT));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 1'b1;
    end else if (req && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (idx == IDX_CTRL) begin
      nxt_rdata[7:0] = ctrl_ff;
    end else if (pat_hit) begin
      nxt_rdata[7:0] = pat_off[0] ? pat_hi_ff[pat_off[2:1]] : pat_lo_ff[pat_off[2:1]];
    end
  end

  // read data captured one edge early so it stands at the completing edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RESET;
    end else if (accept_wr && idx == IDX_CTRL) begin
      ctrl_ff <= avs_writedata[7:0] & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PAT; i++) begin
        pat_lo_ff[i] <= 8'h00;
        pat_hi_ff[i] <= 8'h00;
      end
    end else if (accept_wr && pat_hit) begin
      if (pat_off[0]) begin
        pat_hi_ff[pat_off[2:1]] <= avs_writedata[7:0];
      end else begin
        pat_lo_ff[pat_off[2:1]] <= avs_writedata[7:0];
      end
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // ==========================================================
  // pseudorandom generators, sixteen steps per output word
  logic [22:0] long_lfsr_ff;
  logic [8:0] short_lfsr_ff;

  function automatic logic [22:0] long_step(input logic [22:0] s);
    logic [22:0] v;
    v = s;
    for (int i = 0; i < 16; i++) begin
      v = {v[21:0], v[22] ^ v[LONG_TAP-1]};
    end
    return v;
  endfunction

  function automatic logic [8:0] short_step(input logic [8:0] s);
    logic [8:0] v;
    v = s;
    for (int i = 0; i < 16; i++) begin
      v = {v[7:0], v[8] ^ v[SHORT_TAP-1]};
    end
    return v;
  endfunction

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      long_lfsr_ff <= LONG_SEED;
    end else if (ctrl_ff.long_prbs_hold) begin
      long_lfsr_ff <= LONG_SEED;
    end else begin
      long_lfsr_ff <= long_step(long_lfsr_ff);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_lfsr_ff <= SHORT_SEED;
    end else if (ctrl_ff.short_prbs_hold) begin
      short_lfsr_ff <= SHORT_SEED;
    end else begin
      short_lfsr_ff <= short_step(short_lfsr_ff);
    end
  end

  // ==========================================================
  // user-pattern sequencer
  logic user_mode;
  logic prev_user_ff;
  logic prev_seq_ff;
  logic restart;
  logic [1:0] pat_idx_ff;
  logic done_ff;
  logic alt_ff;

  assign user_mode = (ctrl_ff.mode == MODE_USER);
  // sequencing bit is only looked at in user mode
  assign restart = user_mode && (!prev_user_ff || ctrl_ff.seq_once != prev_seq_ff);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_user_ff <= 1'b0;
      prev_seq_ff <= 1'b0;
    end else begin
      prev_user_ff <= user_mode;
      prev_seq_ff <= ctrl_ff.seq_once;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pat_idx_ff <= 2'h0;
      done_ff <= 1'b0;
    end else if (restart) begin
      pat_idx_ff <= 2'h1;
      done_ff <= 1'b0;
    end else if (user_mode && !done_ff) begin
      pat_idx_ff <= pat_idx_ff + 2'h1;
      done_ff <= ctrl_ff.seq_once && (pat_idx_ff == LAST_PAT);
    end
  end

  // checkerboard and word toggle share one phase bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alt_ff <= 1'b0;
    end else begin
      alt_ff <= ~alt_ff;
    end
  end

  // ==========================================================
  // output selection, registered so the link sees clean words
  logic [15:0] out_ff;
  logic [15:0] nxt_out;

  always_comb begin
    nxt_out = sample_in;
    unique case (ctrl_ff.mode)
      MODE_OFF: nxt_out = sample_in;
      MODE_MID: nxt_out = WORD_MID;
      MODE_POS: nxt_out = WORD_POS;
      MODE_NEG: nxt_out = WORD_NEG;
      MODE_CHECK: nxt_out = alt_ff ? WORD_CHECK_B : WORD_CHECK_A;
      MODE_PN_LONG: nxt_out = long_lfsr_ff[15:0];
      MODE_PN_SHORT: nxt_out = {short_lfsr_ff[7:0], short_lfsr_ff[8:1]};
      MODE_TOGGLE: nxt_out = alt_ff ? WORD_ZERO : WORD_ONES;
      MODE_USER: begin
        if (restart) begin
          nxt_out = {pat_hi_ff[0], pat_lo_ff[0]};
        end else if (done_ff) begin
          nxt_out = WORD_ZERO;
        end else begin
          nxt_out = {pat_hi_ff[pat_idx_ff], pat_lo_ff[pat_idx_ff]};
        end
      end
      // undefined codes fall back to live samples
      default: nxt_out = sample_in;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= WORD_ZERO;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign out_word = out_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_wait_answer: assert property (
    req && wait_ff |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  chk_rsvd_zero: assert property (
    accept_wr && idx == IDX_CTRL |=> ctrl_ff.rsvd == 1'b0 && ctrl_ff.mode == $past(avs_writedata[3:0]))
    else $error("control write stored wrongly or reserved bit set");

  chk_pat_upper: assert property (
    accept_wr && idx == IDX_PAT_BASE + 14'h3 |=> pat_hi_ff[1] == $past(avs_writedata[7:0]))
    else $error("pattern two upper byte not stored");

  chk_normal_pass: assert property (
    ctrl_ff.mode == MODE_OFF |=> out_word == $past(sample_in))
    else $error("normal mode did not pass samples");

  chk_seq_ignored: assert property (
    ctrl_ff.mode == MODE_POS && $changed(ctrl_ff.seq_once) |=> out_word == WORD_POS)
    else $error("sequencing bit disturbed a non-user mode");

  chk_restart_first: assert property (
    restart |=> out_word == {$past(pat_hi_ff[0]), $past(pat_lo_ff[0])} && pat_idx_ff == 2'h1)
    else $error("restart did not present pattern one");

  chk_cont_next: assert property (
    user_mode && !ctrl_ff.seq_once && !restart && !done_ff
      |=> out_word == {$past(pat_hi_ff[pat_idx_ff]), $past(pat_lo_ff[pat_idx_ff])})
    else $error("continuous sequence presented wrong pattern");

  chk_once_zero: assert property (
    user_mode && ctrl_ff.seq_once && pat_idx_ff == LAST_PAT && !restart && !done_ff
      ##1 user_mode && !restart |=> out_word == WORD_ZERO)
    else $error("single sequence did not end in zeros");

  chk_long_hold: assert property (
    ctrl_ff.long_prbs_hold |=> long_lfsr_ff == LONG_SEED)
    else $error("long generator ran while held");

  chk_short_run: assert property (
    !ctrl_ff.short_prbs_hold |=> short_lfsr_ff == short_step($past(short_lfsr_ff)))
    else $error("short generator did not advance");

  chk_short_hold: assert property (
    ctrl_ff.short_prbs_hold |=> short_lfsr_ff == SHORT_SEED)
    else $error("short generator ran while held");

  chk_long_run: assert property (
    !ctrl_ff.long_prbs_hold |=> long_lfsr_ff == long_step($past(long_lfsr_ff)))
    else $error("long generator did not advance");

  // a refused write must not leak into the register, or software cannot trust byte enables
  chk_be_refused: assert property (
    avs_write && !wait_ff && !avs_byteenable[0] |=> $stable(ctrl_ff))
    else $error("write with low byte disabled changed the control register");

  chk_rdata_clean: assert property (
    avs_read && !avs_waitrequest && idx == IDX_CTRL
      |-> avs_readdata[31:8] == 24'h000000 && avs_readdata[6] == 1'b0)
    else $error("control read showed reserved or upper bits");

  chk_neg_word: assert property (
    ctrl_ff.mode == MODE_NEG |=> out_word == WORD_NEG)
    else $error("negative full scale word wrong");

  // two words in a row must be complements, whatever phase the free-running bit had
  chk_check_alt: assert property (
    ctrl_ff.mode == MODE_CHECK ##1 ctrl_ff.mode == MODE_CHECK
      |=> out_word == ~$past(out_word)
        && (out_word == WORD_CHECK_A || out_word == WORD_CHECK_B))
    else $error("checkerboard words did not alternate");


  cov_restart: cover property (restart ##1 !restart [*4]);
  cov_once_done: cover property ($rose(done_ff));
  cov_long_run: cover property (ctrl_ff.mode == MODE_PN_LONG && !ctrl_ff.long_prbs_hold [*3]);
  cov_cont_wrap: cover property (
    user_mode && !ctrl_ff.seq_once && pat_idx_ff == LAST_PAT ##1 user_mode && pat_idx_ff == 2'h0);
  cov_check_mode: cover property (ctrl_ff.mode == MODE_CHECK ##1 ctrl_ff.mode == MODE_CHECK);
endmodule

/* File: tb/otpg_link_rx.sv */
`timescale 1ns/10ps
// ==========================================================
// link receiver model: takes one word per output clock
module otpg_link_rx (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] out_word,
  output logic [15:0] rx_word_ff,
  output logic [15:0] rx_count_ff
);
  import otpg_pkg::*;
  // the receiver never stalls, so every word is taken on its own edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_word_ff <= WORD_ZERO;
      rx_count_ff <= 16'h0000;
    end else begin
      rx_word_ff <= out_word;
      rx_count_ff <= rx_count_ff + 16'h0001;
    end
  end
endmodule

/* File: tb/otpg_tb_top.sv */
`timescale 1ns/10ps
module otpg_tb_top;
  import otpg_pkg::*;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] sample_in, out_word, a, r;
  logic [15:0] pat [4];
  logic [15:0] rx_word;
  // index 0 is never used: mode 0 passes live samples
  logic [15:0] fixed_w [4] = '{WORD_ZERO, WORD_MID, WORD_POS, WORD_NEG};
  logic [7:0] hold_c [4] = '{8'h25, 8'h05, 8'h16, 8'h06};
  logic [7:0] q;
  otpg_ctrl_type c;
  int err_total, check_count;
  otpg_top i_otpg_top (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_in(sample_in), .out_word(out_word));
  otpg_link_rx i_otpg_link_rx (.core_clk(core_clk), .reset_n(reset_n), .out_word(out_word),
    .rx_word_ff(rx_word), .rx_count_ff());
  // ==========================================================
  // helpers
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // one wait state is promised, but the wait is bounded rather than assumed
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] d,
    input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end else begin
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] exp_user(input logic once, input int k);
    return (k < 4) ? pat[k] : (once ? WORD_ZERO : pat[k % 4]);
  endfunction
  // ==========================================================
  // clock, reset and scenarios
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    sample_in = 16'h0000;
    err_total = 0;
    check_count = 0;
    void'($urandom(32'hFB90));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(0, IDX_CTRL, 8'h00, 4'hF);
    chk(q, CTRL_RESET);
    bus(0, IDX_PAT_BASE, 8'h00, 4'hF);
    chk(q, 8'h00);
    bus(1, IDX_CTRL, 8'hFF, 4'hF);
    bus(0, IDX_CTRL, 8'h00, 4'hF);
    chk(q, 8'hFF & CTRL_WR_MASK);
    bus(1, IDX_CTRL, 8'h02, 4'h0);
    bus(1, 14'h0559, 8'h5A, 4'hF);
    bus(0, 14'h0559, 8'h00, 4'hF);
    chk(q, 8'h00);
    bus(0, IDX_CTRL, 8'h00, 4'hF);
    chk(q, 8'hBF);
    // sequencing bit follows the low mode bit: it must not disturb the non-user modes, the pseudorandom modes 5 and 6 are skipped
    for (int m = 0; m < 16; m++) begin
      if (m == 5 || m == 6 || m == 8) continue;
      bus(1, IDX_CTRL, {m[0], 3'b000, m[3:0]}, 4'hF);
      for (int k = 0; k < 4; k++) begin
        r = 16'($urandom);
        sample_in <= r;
        tick();
        a = out_word;
        if (m == 0 || m > 8) chk(a, r);
        else if (m < 4) chk(a, fixed_w[m]);
        else if (k > 0) chk({a === ~pat[0], 1'b0}, 2'b10);
        pat[0] = a;
      end
    end
    for (int k = 0; k < 4; k++) begin
      pat[k] = 16'($urandom);
      // pattern four never zero, so the start of the zero tail is visible
      if (k == 3) pat[k] = pat[k] | 16'h8001;
      bus(1, IDX_PAT_BASE + 14'(2 * k), pat[k][7:0], 4'hF);
      bus(1, IDX_PAT_BASE + 14'(2 * k + 1), pat[k][15:8], 4'hF);
    end
    for (int s = 0; s < 3; s++) begin
      c = CTRL_RESET;
      c.seq_once = (s == 1);
      c.mode = MODE_USER;
      bus(1, IDX_CTRL, c, 4'hF);
      for (int k = 0; k < 10; k++) begin
        tick();
        chk(out_word, exp_user(c.seq_once, k));
        if (k > 0) chk(rx_word, exp_user(c.seq_once, k - 1));
      end
    end
    // held generator reloads its seed, so its word stands still
    for (int h = 0; h < 4; h += 2) begin
      bus(1, IDX_CTRL, hold_c[h], 4'hF);
      // the first word after the write still carries the running value
      repeat (2) tick();
      a = out_word;
      repeat (3) begin
        tick();
        chk(out_word, a);
      end
      bus(1, IDX_CTRL, hold_c[h + 1], 4'hF);
      tick();
      a = out_word;
      tick();
      chk(out_word !== a, 1'b1);
    end
    end_of_test();
  end
endmodule
